// file: hw/ts_cfg.svh
// Constants of the reference-clock timestamp counter: offsets, codes, sizes.
// Assumes inclusion by the package, the counter module, the monitor and the bench.
`ifndef TS_CFG_SVH
`define TS_CFG_SVH

`define TS_ADDR_W         16
`define TS_DATA_W         32
`define TS_OFS_COMMAND    16'hb798
`define TS_OFS_FIFO_STATE 16'hb7a2
`define TS_OFS_START_SEC  16'hb7b6
`define TS_OFS_FIFO_WORD  16'hb7c0
`define TS_OFS_EDGE_SEL   16'hb7ca

`define TS_CMD_CLEAR      32'h0000_0000
`define TS_CMD_OFF        32'h0000_000a
`define TS_CMD_STANDARD   32'h0000_000c
`define TS_CMD_REFCLOCK   32'h0000_000d
`define TS_MODE_RESET     32'h0000_000a

`define TS_EDGE_RISING    32'h0000_000a
`define TS_EDGE_FALLING   32'h0000_0014
`define TS_EDGE_RESET     32'h0000_000a

`define TS_QUEUE_EMPTY    2'h0
`define TS_QUEUE_UNDER    2'h1
`define TS_QUEUE_OVER     2'h2
`define TS_QUEUE_FULL     2'h3

`define TS_CNT_W          56
`define TS_LOW_W          32
`define TS_HIGH_W         24
`define TS_DEPTH_LOG2     16
`define TS_DEPTH          17'h1_0000
`define TS_HALF           17'h0_8000

`endif

// file: hw/ts_pkg.sv
// Types shared by the timestamp counter and its bench.
// Assumes ts_cfg.svh is on the include path.
`include "ts_cfg.svh"

package ts_pkg;

  typedef struct packed {
    logic [`TS_ADDR_W-1:0] addr;
    logic [`TS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    sync_idle,
    sync_wait_edge,
    sync_run
  } sync_state_t;

endpackage

// file: hw/refclock_timestamp_counter.sv
// Timestamp counter with reference-clock mode and a 64K-entry capture queue.
// Assumes a single sample clock, a same-clock capture strobe and an
// asynchronous seconds pulse pin.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "ts_cfg.svh"

module refclock_timestamp_counter (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire ts_pkg::reg_req_t      reg_req,
  output logic [`TS_DATA_W-1:0]      reg_rdata,
  input  wire logic                  capture_strobe,
  input  wire logic                  seconds_pulse,
  input  wire logic [`TS_DATA_W-1:0] epoch_seconds,
  output logic                       counter_synced
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Seconds pulse synchroniser and edge detector
  // ----------------------------------------------------------------
  // The first stage feeds only the second; a change is accepted once the
  // second and third stages agree, which also rejects single-cycle noise.
  logic [2:0] pulse_sync_q;
  logic       pulse_level_q;
  logic       pulse_level_d;
  logic       rise_seen;
  logic       fall_seen;
  logic       active_edge;

  always_comb begin
    pulse_level_d = pulse_level_q;
    if (pulse_sync_q[1] == pulse_sync_q[2]) begin
      pulse_level_d = pulse_sync_q[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_sync_q  <= 3'h0;
      pulse_level_q <= 1'h0;
    end else begin
      pulse_sync_q  <= {pulse_sync_q[1:0], seconds_pulse};
      pulse_level_q <= pulse_level_d;
    end
  end

  assign rise_seen = pulse_level_d & ~pulse_level_q;
  assign fall_seen = ~pulse_level_d & pulse_level_q;

  // ----------------------------------------------------------------
  // Register writes: mode, edge select, clear command
  // ----------------------------------------------------------------
  logic [`TS_DATA_W-1:0] mode_q;
  logic [`TS_DATA_W-1:0] mode_d;
  logic [`TS_DATA_W-1:0] edge_sel_q;
  logic [`TS_DATA_W-1:0] edge_sel_d;
  logic                  cmd_wr;
  logic                  clear_cmd;

  assign cmd_wr    = reg_req.wr && reg_req.addr == `TS_OFS_COMMAND;
  assign clear_cmd = cmd_wr && reg_req.wdata == `TS_CMD_CLEAR;

  always_comb begin
    mode_d     = mode_q;
    edge_sel_d = edge_sel_q;
    if (cmd_wr && (reg_req.wdata == `TS_CMD_OFF ||
                   reg_req.wdata == `TS_CMD_STANDARD ||
                   reg_req.wdata == `TS_CMD_REFCLOCK)) begin
      mode_d = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == `TS_OFS_EDGE_SEL &&
        (reg_req.wdata == `TS_EDGE_RISING ||
         reg_req.wdata == `TS_EDGE_FALLING)) begin
      edge_sel_d = reg_req.wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q     <= `TS_MODE_RESET;
      edge_sel_q <= `TS_EDGE_RESET;
    end else begin
      mode_q     <= mode_d;
      edge_sel_q <= edge_sel_d;
    end
  end

  assign active_edge = (edge_sel_q == `TS_EDGE_FALLING) ? fall_seen
                                                        : rise_seen;

  // ----------------------------------------------------------------
  // Counter and synchronisation sequence
  // ----------------------------------------------------------------
  // Selecting a mode never clears the counter; software follows it with the
  // clear command. In reference mode the clear waits for the next active
  // pulse edge, up to one second, before counting resumes.
  logic                    refclock;
  ts_pkg::sync_state_t     sync_q;
  ts_pkg::sync_state_t     sync_d;
  logic [`TS_LOW_W-1:0]    low_q;
  logic [`TS_LOW_W-1:0]    low_d;
  logic [`TS_HIGH_W-1:0]   high_q;
  logic [`TS_HIGH_W-1:0]   high_d;
  logic [`TS_DATA_W-1:0]   start_sec_q;
  logic [`TS_DATA_W-1:0]   start_sec_d;
  logic [`TS_CNT_W-1:0]    count_value;

  assign refclock    = mode_q == `TS_CMD_REFCLOCK;
  assign count_value = {high_q, low_q};

  always_comb begin
    sync_d      = sync_q;
    low_d       = low_q;
    high_d      = high_q;
    start_sec_d = start_sec_q;
    if (clear_cmd) begin
      // Edge selection plays no part here: the whole counter is zeroed.
      low_d  = '0;
      high_d = '0;
      sync_d = refclock ? ts_pkg::sync_wait_edge
                        : ts_pkg::sync_run;
    end else begin
      unique case (sync_q)
        ts_pkg::sync_idle: begin
          sync_d = sync_q;
        end
        ts_pkg::sync_wait_edge: begin
          if (active_edge) begin
            sync_d      = ts_pkg::sync_run;
            start_sec_d = epoch_seconds;
          end
        end
        ts_pkg::sync_run: begin
          if (refclock) begin
            if (active_edge) begin
              low_d  = '0;
              high_d = high_q + `TS_HIGH_W'(1);
            end else begin
              low_d = low_q + `TS_LOW_W'(1);
            end
          end else begin
            {high_d, low_d} = count_value + `TS_CNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_q      <= ts_pkg::sync_idle;
      low_q       <= '0;
      high_q      <= '0;
      start_sec_q <= '0;
    end else begin
      sync_q      <= sync_d;
      low_q       <= low_d;
      high_q      <= high_d;
      start_sec_q <= start_sec_d;
    end
  end

  assign counter_synced = sync_q == ts_pkg::sync_run;

  // ----------------------------------------------------------------
  // Capture queue
  // ----------------------------------------------------------------
  // Entries are 56 bits wide; the upper word reads back zero-padded.
  logic [`TS_CNT_W-1:0]      queue_mem [0:`TS_DEPTH-1];
  logic [`TS_DEPTH_LOG2-1:0] wr_ptr_q;
  logic [`TS_DEPTH_LOG2-1:0] wr_ptr_d;
  logic [`TS_DEPTH_LOG2-1:0] rd_ptr_q;
  logic [`TS_DEPTH_LOG2-1:0] rd_ptr_d;
  logic [`TS_DEPTH_LOG2:0]   fill_q;
  logic [`TS_DEPTH_LOG2:0]   fill_d;
  logic                      high_next_q;
  logic                      high_next_d;
  logic                      lost_q;
  logic                      lost_d;
  logic                      push_req;
  logic                      push;
  logic                      word_rd;
  logic                      pop;
  logic [`TS_CNT_W-1:0]      head;

  assign push_req = capture_strobe && mode_q != `TS_CMD_OFF;
  assign push     = push_req && fill_q != `TS_DEPTH;
  assign word_rd  = reg_req.rd && reg_req.addr == `TS_OFS_FIFO_WORD;
  assign pop      = word_rd && high_next_q && fill_q != '0;
  assign head     = queue_mem[rd_ptr_q];

  always_comb begin
    wr_ptr_d    = wr_ptr_q;
    rd_ptr_d    = rd_ptr_q;
    fill_d      = fill_q;
    high_next_d = high_next_q;
    lost_d      = lost_q;
    if (push) begin
      wr_ptr_d = wr_ptr_q + `TS_DEPTH_LOG2'(1);
    end
    if (word_rd && fill_q != '0) begin
      high_next_d = ~high_next_q;
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + `TS_DEPTH_LOG2'(1);
    end
    if (push && !pop) begin
      fill_d = fill_q + (`TS_DEPTH_LOG2+1)'(1);
    end else if (pop && !push) begin
      fill_d = fill_q - (`TS_DEPTH_LOG2+1)'(1);
    end
    // A drop in the same cycle as the emptying pop still marks the loss.
    if (push_req && !push) begin
      lost_d = 1'h1;
    end else if (fill_d == '0 || clear_cmd) begin
      lost_d = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      queue_mem[wr_ptr_q] <= count_value;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      fill_q      <= '0;
      high_next_q <= 1'h0;
      lost_q      <= 1'h0;
    end else begin
      wr_ptr_q    <= wr_ptr_d;
      rd_ptr_q    <= rd_ptr_d;
      fill_q      <= fill_d;
      high_next_q <= high_next_d;
      lost_q      <= lost_d;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [1:0]            queue_code;
  logic [`TS_DATA_W-1:0] rdata_d;

  always_comb begin
    if (fill_q == `TS_DEPTH || lost_q) begin
      queue_code = `TS_QUEUE_FULL;
    end else if (fill_q > `TS_HALF) begin
      queue_code = `TS_QUEUE_OVER;
    end else if (fill_q != '0) begin
      queue_code = `TS_QUEUE_UNDER;
    end else begin
      queue_code = `TS_QUEUE_EMPTY;
    end
  end

  always_comb begin
    rdata_d = '0;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `TS_OFS_COMMAND:    rdata_d = mode_q;
        `TS_OFS_EDGE_SEL:   rdata_d = edge_sel_q;
        `TS_OFS_START_SEC:  rdata_d = start_sec_q;
        `TS_OFS_FIFO_STATE: rdata_d = {30'h0, queue_code};
        `TS_OFS_FIFO_WORD: begin
          if (fill_q == '0) begin
            rdata_d = '0;
          end else if (high_next_q) begin
            rdata_d = {8'h00, head[`TS_CNT_W-1:`TS_LOW_W]};
          end else begin
            rdata_d = head[`TS_LOW_W-1:0];
          end
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule // refclock_timestamp_counter

// file: verification/ts_monitor.sv
// Port checker for the timestamp counter: bus answers and sync behaviour.
// Assumes it is bound onto refclock_timestamp_counter; one clock domain.
`timescale 1ns/1ps
`include "ts_cfg.svh"

module ts_monitor (
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire ts_pkg::reg_req_t      reg_req,
  input wire logic [`TS_DATA_W-1:0] reg_rdata,
  input wire logic                  capture_strobe,
  input wire logic                  seconds_pulse,
  input wire logic [`TS_DATA_W-1:0] epoch_seconds,
  input wire logic                  counter_synced
);
  localparam int SYNC_MAX = 600;
  logic [`TS_DATA_W-1:0] mode_q;
  logic                  cmd_wr;
  logic                  ref_m;
  logic                  mapped;
  logic                  synced_q;
  logic                  waiting_q;
  logic [`TS_DATA_W-1:0] epoch_q;
  logic [`TS_DATA_W-1:0] start_q;
  assign cmd_wr = reg_req.wr && reg_req.addr == `TS_OFS_COMMAND;
  assign ref_m  = mode_q == `TS_CMD_REFCLOCK;
  assign mapped = reg_req.addr inside {`TS_OFS_COMMAND, `TS_OFS_FIFO_STATE,
    `TS_OFS_START_SEC, `TS_OFS_FIFO_WORD, `TS_OFS_EDGE_SEL};

  // The clear code is a command, not a mode, so it never enters the mirror.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `TS_MODE_RESET;
    end else if (cmd_wr && reg_req.wdata inside
        {`TS_CMD_OFF, `TS_CMD_STANDARD, `TS_CMD_REFCLOCK}) begin
      mode_q <= reg_req.wdata;
    end
  end

  // Mirror of the start time: the epoch value in the cycle in which a
  // waiting counter locks to the pulse edge. Waiting is tracked from the
  // clear itself, so a mode change during the wait cannot mislead it.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      synced_q  <= 1'b0;
      waiting_q <= 1'b0;
      epoch_q   <= '0;
      start_q   <= '0;
    end else begin
      synced_q <= counter_synced;
      epoch_q  <= epoch_seconds;
      if (cmd_wr && reg_req.wdata == `TS_CMD_CLEAR) begin
        waiting_q <= ref_m;
      end else if (counter_synced) begin
        waiting_q <= 1'b0;
      end
      if (waiting_q && counter_synced && !synced_q) begin
        start_q <= epoch_q;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_clear_ref;
    ref_m && cmd_wr && reg_req.wdata == `TS_CMD_CLEAR;
  endsequence
  sequence s_quiet_pin;
    (ref_m && $stable(seconds_pulse))[*8] ##0 !counter_synced;
  endsequence
  sequence s_push_state;
    capture_strobe && mode_q != `TS_CMD_OFF ##1 !reg_req.rd
      ##1 reg_req.rd && reg_req.addr == `TS_OFS_FIFO_STATE;
  endsequence

  property p_idle_zero; !reg_req.rd |=> reg_rdata == 32'h0; endproperty
  property p_unmapped; reg_req.rd && !mapped |=> reg_rdata == 32'h0;
  endproperty
  property p_mode_read; reg_req.rd && reg_req.addr == `TS_OFS_COMMAND
    |=> reg_rdata == $past(mode_q); endproperty
  property p_edge_read; reg_req.rd && reg_req.addr == `TS_OFS_EDGE_SEL
    |=> reg_rdata inside {`TS_EDGE_RISING, `TS_EDGE_FALLING}; endproperty
  property p_state_code; reg_req.rd && reg_req.addr == `TS_OFS_FIFO_STATE
    |=> reg_rdata[31:2] == 30'h0; endproperty
  property p_clear_drop; s_clear_ref |=> !counter_synced; endproperty
  property p_sync_bound; s_clear_ref |-> ##[1:SYNC_MAX] counter_synced;
  endproperty
  property p_needs_edge; s_quiet_pin |=> !counter_synced; endproperty
  property p_keeps_run; counter_synced && !cmd_wr |=> counter_synced;
  endproperty
  property p_push_shows;
    s_push_state |=> reg_rdata[1:0] != `TS_QUEUE_EMPTY;
  endproperty
  property p_start_read; reg_req.rd && reg_req.addr == `TS_OFS_START_SEC
    |=> reg_rdata == start_q; endproperty

  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero outside a read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_mode_read: assert property (p_mode_read)
    else $error("command read is not the selected mode");
  a_edge_read: assert property (p_edge_read)
    else $error("edge select holds an illegal value");
  a_state_code: assert property (p_state_code)
    else $error("status read wider than two bits");
  a_clear_drop: assert property (p_clear_drop)
    else $error("clear did not stop the counter");
  a_sync_bound: assert property (p_sync_bound)
    else $error("sync after clear took too long");
  a_needs_edge: assert property (p_needs_edge)
    else $error("sync without a pulse edge");
  a_keeps_run: assert property (p_keeps_run)
    else $error("counter stopped without a command");
  a_push_shows: assert property (p_push_shows)
    else $error("captured value missing from queue status");
  a_start_read: assert property (p_start_read)
    else $error("start time read differs from locked epoch");
endmodule // ts_monitor

bind refclock_timestamp_counter ts_monitor i_mon (
  .clock(clock), .reset_n(reset_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .capture_strobe(capture_strobe),
  .seconds_pulse(seconds_pulse), .epoch_seconds(epoch_seconds),
  .counter_synced(counter_synced));

// file: verification/pulse_source.sv
// Stand-in for the external seconds reference pulse.
// Assumes the bench accepts a shortened period; the counter never times it.
`timescale 1ns/1ps

module pulse_source #(
  parameter int PERIOD_NS = 8000,
  parameter int HIGH_NS   = 2000
) (
  output logic seconds_pulse
);
  // Free running and out of phase with the sample clock, as a real pin is.
  initial begin
    seconds_pulse = 1'b0;
    #1013;
    forever begin
      seconds_pulse = 1'b1;
      #(HIGH_NS);
      seconds_pulse = 1'b0;
      #(PERIOD_NS - HIGH_NS);
    end
  end
endmodule // pulse_source

// file: verification/test_refclock_timestamp_counter.sv
// Self-checking bench for the reference-clock timestamp counter.
// Assumes ts_monitor is bound by its own file and pulse_source is compiled.
`timescale 1ns/1ps
`include "ts_cfg.svh"

module test_refclock_timestamp_counter;
  logic                  clock, reset_n, cs, pulse, synced;
  logic [`TS_DATA_W-1:0] rdata, epoch, v, lo;
  logic [`TS_CNT_W-1:0]  t0, t1;
  ts_pkg::reg_req_t      req;
  int                    mismatches, n_checks, seed, k;

  pulse_source i_src (.seconds_pulse(pulse));
  refclock_timestamp_counter i_dut (.clock(clock), .reset_n(reset_n),
    .reg_req(req), .reg_rdata(rdata), .capture_strobe(cs),
    .seconds_pulse(pulse), .epoch_seconds(epoch), .counter_synced(synced));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Bus, capture and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [`TS_CNT_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  // A stored value is two reads: low word, then the word that pops it.
  task automatic pop(output logic [`TS_CNT_W-1:0] t);
    rd(`TS_OFS_FIFO_WORD);
    lo = v;
    rd(`TS_OFS_FIFO_WORD);
    t = {v[23:0], lo};
  endtask
  task automatic cap(input int n);
    @(posedge clock);
    cs <= 1'b1;
    repeat (n) @(posedge clock);
    cs <= 1'b0;
  endtask
  // Bounded waits; running out counts as a mismatch and ends the run.
  task automatic wait_for(input logic on_sync, input logic lvl);
    for (int i = 0; i < 600; i++) begin
      @(posedge clock);
      #1;
      if ((on_sync ? synced : pulse) === lvl) return;
    end
    mismatches++;
    tally_and_finish;
  endtask

  initial begin
    seed = 40;
    req = '0;
    cs = 1'b0;
    reset_n = 1'b0;
    epoch = $random(seed);
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rchk(`TS_OFS_COMMAND, `TS_MODE_RESET);
    rchk(`TS_OFS_EDGE_SEL, `TS_EDGE_RESET);
    rchk(16'(($random(seed)) & 8'hff), 32'h0);
    cap(1);
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_EMPTY);
    rchk(`TS_OFS_FIFO_WORD, 32'h0);
    wr(`TS_OFS_EDGE_SEL, `TS_EDGE_FALLING);
    wr(`TS_OFS_EDGE_SEL, 32'h0000_0015);
    rchk(`TS_OFS_EDGE_SEL, `TS_EDGE_FALLING);
    for (int e = 0; e < 2; e++) begin
      wr(`TS_OFS_EDGE_SEL, e ? `TS_EDGE_FALLING : `TS_EDGE_RISING);
      wr(`TS_OFS_COMMAND, `TS_CMD_REFCLOCK);
      rchk(`TS_OFS_COMMAND, `TS_CMD_REFCLOCK);
      wr(`TS_OFS_COMMAND, `TS_CMD_CLEAR);
      #1 chk(synced, 1'b0);
      wait_for(1'b1, 1'b1);
      chk(pulse, !e);
      k = 2 + ($random(seed) & 15);
      cap(1);
      repeat (k - 2) @(posedge clock);
      cap(1);
      pop(t0);
      pop(t1);
      chk(t0[55:32], 0);
      chk(t1[31:0] - t0[31:0], k);
      // Move the live epoch on, so the register must hold the locked value.
      lo = epoch;
      @(posedge clock);
      epoch <= ~epoch;
      wr(`TS_OFS_START_SEC, 32'h0000_0001);
      rchk(`TS_OFS_START_SEC, lo);
      wait_for(1'b0, e);
      wait_for(1'b0, !e);
      repeat (10) @(posedge clock);
      cap(1);
      pop(t0);
      chk(t0[55:32], 1);
      chk(t0[31:0] < 32'h1e, 1);
    end
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_EMPTY);
    wr(`TS_OFS_COMMAND, `TS_CMD_STANDARD);
    wr(`TS_OFS_COMMAND, `TS_CMD_CLEAR);
    cap(32768);
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_UNDER);
    cap(1);
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_OVER);
    cap(32767);
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_FULL);
    cap(1);
    pop(t0);
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_FULL);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rchk(`TS_OFS_FIFO_STATE, `TS_QUEUE_EMPTY);
    tally_and_finish;
  end
endmodule // test_refclock_timestamp_counter
